/* File: sim/shcs_cpu_model.sv */
module shcs_cpu_model (
  input wire logic clk, // Clock
  output logic halt_exec, // Halt
  output logic [3:0] halt_mask, // Operand
  output logic stop_exec, // Stop
  output logic dev_en_pin // Enable pin
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    halt_exec = 1'b0;
    halt_mask = 4'h5;
    stop_exec = 1'b0;
    dev_en_pin = 1'b0;
  end
  task automatic halt(input logic [3:0] m);
    @(posedge clk);
    halt_exec <= 1'b1;
    halt_mask <= m & 4'hB;
    @(posedge clk);
    halt_exec <= 1'b0;
    halt_mask <= ~m;
  endtask
  task automatic stop;
    @(posedge clk);
    stop_exec <= 1'b1;
    @(posedge clk);
    stop_exec <= 1'b0;
  endtask
  task automatic pin(input logic v);
    @(posedge clk);
    dev_en_pin <= v;
  endtask
endmodule

/* File: sim/shcs_monitor.sv */
module shcs_monitor (
  input wire logic clk, // Clock
  input wire logic sys_rst, // Reset
  input wire logic clk_en, // Freeze
  input wire logic halt_exec, // Halt
  input wire logic [3:0] halt_mask, // Operand
  input wire logic stop_exec, // Stop
  input wire logic timer_carry, // Carry
  input wire logic irq_ack, // Ack
  input wire logic [3:0] key_pins, // Keys
  input wire logic cpu_clk_en, // CPU clock
  input wire logic osc_run, // Oscillator
  input wire logic dev_reset, // Reset out
  input wire logic resume_next, // Resume
  input wire logic vector_take, // Vector
  input wire logic dev_en_flag, // Flag
  input wire logic halted // Halted
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] mask_q;
  // Copy of the operand of the halt in force
  always_ff @(posedge clk) begin
    if (clk_en && halt_exec && cpu_clk_en) begin
      mask_q <= halt_mask;
    end
  end
  default clocking @(posedge clk);
  endclocking
  default disable iff (sys_rst || !clk_en);
  a_halt_entry: assert property (halt_exec && cpu_clk_en |=> halted && !cpu_clk_en)
    else $error("no halt");
  a_timer_rel: assert property (halted && mask_q[1] && timer_carry && !(mask_q[3] && irq_ack)
    |=> resume_next && !halted)
    else $error("no timer release");
  a_irq_rel: assert property (halted && mask_q[3] && irq_ack |=> vector_take && cpu_clk_en)
    else $error("no vector");
  a_zero_mask: assert property (halted && mask_q == 4'h0 |=> halted || dev_reset)
    else $error("zero mask released");
  a_key_rel: assert property (halted && mask_q[0] && key_pins != 4'h0 |-> ##[1:4] !halted)
    else $error("no key release");
  a_stop_nop: assert property (stop_exec && cpu_clk_en && !halt_exec && dev_en_flag |=> osc_run)
    else $error("stop not ignored");
  a_stop_go: assert property (stop_exec && cpu_clk_en && !halt_exec && !dev_en_flag
    |=> !osc_run && !cpu_clk_en)
    else $error("stop ignored");
  a_en_reset: assert property ($rose(dev_en_flag) |-> ##[0:2] dev_reset)
    else $error("no enable reset");
endmodule

/* File: sim/standby_halt_clock_stop_control_tb_top.sv */
module standby_halt_clock_stop_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic sys_rst, clk_en, psel, penable, pwrite, timer_carry, irq_ack;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [3:0] pstrb, key_pins;
  logic [31:0] prdata, rd;
  logic [3:0] halt_mask;
  logic pready, pslverr, er, halt_exec, stop_exec, dev_en_pin, cpu_clk_en, periph_run;
  logic osc_run, dev_reset, resume_next, vector_take, dev_en_flag, halted;
  int num_errors = 0;
  int n_tests = 0;
  always #4 clk = ~clk;
  shcs_top dut (.clk, .sys_rst, .clk_en, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .halt_exec, .halt_mask, .stop_exec, .timer_carry, .irq_ack,
    .key_pins, .dev_en_pin, .cpu_clk_en, .periph_run, .osc_run, .dev_reset, .resume_next,
    .vector_take, .dev_en_flag, .halted);
  shcs_cpu_model cpu (.clk, .halt_exec, .halt_mask, .stop_exec, .dev_en_pin);
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic chb(input logic g, input logic e);
    chk({31'h0, g}, {31'h0, e});
  endtask
  task automatic settle(input int k);
    repeat (k) begin
      @(posedge clk);
      #1;
    end
  endtask
  task automatic wflag(input logic v);
    for (int n = 0; n < 40 && dev_en_flag !== v; n++) begin
      settle(1);
    end
  endtask
  task automatic wrun;
    for (int n = 0; n < 40 && cpu_clk_en !== 1'b1; n++) begin
      settle(1);
    end
  endtask
  task automatic ap(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chb(pready, 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;
  endtask
  task automatic t_pin;
    cpu.pin(1'b1);
    cpu.pin(1'b0);
    settle(10);
    chb(dev_en_flag, 1'b0);
    cpu.pin(1'b1);
    wflag(1'b1);
    settle(2);
    chb(dev_reset, 1'b1);
    wrun;
    chb(periph_run, 1'b1);
    ap(1'b0, 8'h00, 32'h0000_0000);
    chk(rd, 32'h0000_0011);
  endtask
  task automatic t_halt;
    cpu.halt(4'h2);
    #1;
    chb(halted, 1'b1);
    chb(cpu_clk_en, 1'b0);
    settle(4);
    chb(periph_run, 1'b1);
    @(posedge clk);
    timer_carry <= 1'b1;
    @(posedge clk);
    timer_carry <= 1'b0;
    #1;
    chb(resume_next, 1'b1);
    chb(cpu_clk_en, 1'b1);
    cpu.halt(4'hB);
    @(posedge clk);
    key_pins <= 4'h4;
    for (int n = 0; n < 8 && resume_next !== 1'b1; n++) begin
      settle(1);
    end
    chb(resume_next, 1'b1);
    chb(vector_take, 1'b0);
    @(posedge clk);
    key_pins <= 4'h0;
  endtask
  task automatic t_irq;
    cpu.halt(4'h8);
    @(posedge clk);
    timer_carry <= 1'b1;
    settle(3);
    chb(halted, 1'b1);
    @(posedge clk);
    timer_carry <= 1'b0;
    irq_ack <= 1'b1;
    @(posedge clk);
    irq_ack <= 1'b0;
    #1;
    chb(vector_take, 1'b1);
    ap(1'b0, 8'h0C, 32'h0000_0000);
    chk(rd, 32'h0000_0008);
  endtask
  task automatic t_zero;
    cpu.halt(4'h0);
    @(posedge clk);
    timer_carry <= 1'b1;
    irq_ack <= 1'b1;
    key_pins <= 4'hF;
    @(posedge clk);
    irq_ack <= 1'b0;
    settle(6);
    chb(halted, 1'b1);
    ap(1'b0, 8'h00, 32'h0000_0000);
    chk(rd, 32'h0000_0013);
    cpu.pin(1'b0);
    timer_carry <= 1'b0;
    key_pins <= 4'h0;
    wflag(1'b0);
    settle(1);
    chb(periph_run, 1'b0);
    cpu.pin(1'b1);
    wflag(1'b1);
    settle(2);
    chb(halted, 1'b0);
    wrun;
  endtask
  task automatic t_stop;
    cpu.stop;
    settle(2);
    chb(osc_run, 1'b1);
    ap(1'b0, 8'h08, 32'h0000_0000);
    chb(rd[4], 1'b1);
    pstrb <= 4'hE;
    ap(1'b1, 8'h08, 32'h0000_003F);
    ap(1'b0, 8'h08, 32'h0000_0000);
    chb(rd[4], 1'b1);
    pstrb <= 4'hF;
    ap(1'b1, 8'h08, 32'h0000_003F);
    ap(1'b0, 8'h08, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    cpu.pin(1'b0);
    wflag(1'b0);
    cpu.stop;
    #1;
    chb(osc_run, 1'b0);
    ap(1'b0, 8'h00, 32'h0000_0000);
    chk(rd, 32'h0000_0004);
    cpu.pin(1'b1);
    wflag(1'b1);
    wrun;
    chb(osc_run, 1'b1);
  endtask
  // Clock enable low must freeze the halt: a carry seen while frozen is lost
  task automatic t_freeze;
    cpu.halt(4'h2);
    @(posedge clk);
    clk_en <= 1'b0;
    @(posedge clk);
    timer_carry <= 1'b1;
    settle(3);
    chb(halted, 1'b1);
    @(posedge clk);
    timer_carry <= 1'b0;
    settle(1);
    @(posedge clk);
    clk_en <= 1'b1;
    settle(2);
    chb(halted, 1'b1);
    @(posedge clk);
    timer_carry <= 1'b1;
    @(posedge clk);
    timer_carry <= 1'b0;
    #1;
    chb(resume_next, 1'b1);
    chb(cpu_clk_en, 1'b1);
  endtask
  task automatic t_regs;
    chb(periph_run, 1'b0);
    ap(1'b1, 8'h04, 32'h0000_0002);
    ap(1'b0, 8'h04, 32'h0000_0000);
    chk(rd, 32'h0000_0002);
    pstrb <= 4'h1;
    ap(1'b1, 8'h04, 32'h0000_FF03);
    pstrb <= 4'hF;
    ap(1'b0, 8'h04, 32'h0000_0000);
    chk(rd, 32'h0000_0003);
    ap(1'b0, 8'h10, 32'h0000_0000);
    chb(er, 1'b1);
    ap(1'b1, 8'h00, 32'h0000_001F);
    chb(er, 1'b1);
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    sys_rst <= 1'b1;
    clk_en <= 1'b1;
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    timer_carry <= 1'b0;
    irq_ack <= 1'b0;
    paddr <= 8'h00;
    pwdata <= 32'h0000_0000;
    pstrb <= 4'hF;
    key_pins <= 4'h0;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    wrun;
    t_regs;
    t_pin;
    t_halt;
    t_irq;
    t_zero;
    t_stop;
    t_freeze;
    report_and_stop;
  end
  initial begin
    #100000;
    num_errors++;
    report_and_stop;
  end
endmodule
bind shcs_top shcs_monitor u_mon (.clk, .sys_rst, .clk_en, .halt_exec, .halt_mask, .stop_exec,
  .timer_carry, .irq_ack, .key_pins, .cpu_clk_en, .osc_run, .dev_reset, .resume_next,
  .vector_take, .dev_en_flag, .halted);

/* File: verilog/shcs_consts.svh */
`ifndef SHCS_CONSTS_SVH
`define SHCS_CONSTS_SVH

// Clock
`define SHCS_CLK_PERIOD_NS 8

// Register byte offsets
`define SHCS_OFS_STATUS 8'h00
`define SHCS_OFS_FILTER 8'h04
`define SHCS_OFS_CAUSE 8'h08
`define SHCS_OFS_MASK 8'h0C

// Status register fields
`define SHCS_ST_DEV_EN 0
`define SHCS_ST_HALTED 1
`define SHCS_ST_STOPPED 2
`define SHCS_ST_IN_RESET 3
`define SHCS_ST_PERIPH 4

// Cause register fields (sticky, write one to clear)
`define SHCS_CA_KEY 0
`define SHCS_CA_TIMER 1
`define SHCS_CA_IRQ 3
`define SHCS_CA_STOP_NOP 4
`define SHCS_CA_DEV_RESET 5
`define SHCS_CA_WIDTH 6

// Halt release mask bits
`define SHCS_HM_KEY 0
`define SHCS_HM_TIMER 1
`define SHCS_HM_UNUSED 2
`define SHCS_HM_IRQ 3

// Enable pin filter: least time a level must persist
`define SHCS_FILT_TIME_NS 1000
`define SHCS_FILT_CYCLES \
  ((`SHCS_FILT_TIME_NS + `SHCS_CLK_PERIOD_NS - 1) / `SHCS_CLK_PERIOD_NS)
`define SHCS_FILT_RESET 16'h007D

// Internal reset pulse length after power-on or enable-pin rise
`define SHCS_RST_TIME_NS 64
`define SHCS_RST_CYCLES \
  ((`SHCS_RST_TIME_NS + `SHCS_CLK_PERIOD_NS - 1) / `SHCS_CLK_PERIOD_NS)

`endif

/* File: verilog/shcs_filter.sv */
`include "shcs_consts.svh"

module shcs_filter (
  input wire logic clk,              // System clock
  input wire logic sys_rst,          // Synchronous reset, active high
  input wire logic clk_en,           // Freezes state while low
  input wire logic level_in,         // Synchronised pin level
  input wire logic [15:0] filt_len,  // Cycles a new level must persist
  output logic level_out,            // Accepted level
  output logic rise                  // One-cycle pulse on accepted rise
);

  logic [15:0] cnt;
  wire logic [15:0] limit;
  wire logic differs;
  wire logic accept;

  // A zero setting behaves as one cycle
  assign limit = (filt_len == 16'h0000) ? 16'h0001 : filt_len;
  assign differs = level_in != level_out;
  assign accept = differs && (cnt >= 16'(limit - 16'h0001));

  // Short glitches reset the count and never reach the output
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt <= 16'h0000;
      level_out <= 1'b0;
      rise <= 1'b0;
    end else if (clk_en) begin
      cnt <= (!differs || accept) ? 16'h0000 : 16'(cnt + 16'h0001);
      if (accept) begin
        level_out <= level_in;
      end
      rise <= accept && level_in;
    end
  end

endmodule

/* File: verilog/shcs_pkg.sv */
package shcs_pkg;

  typedef enum logic [1:0] {
    SHCS_RESET,
    SHCS_RUN,
    SHCS_HALT,
    SHCS_STOP
  } shcs_state_t;

  typedef logic [3:0] shcs_mask_t;

endpackage

/* File: verilog/shcs_top.sv */
// Overview of operation
// - Peripherals run only while enable pin high
// - Stop honoured only while enable pin low
// - Enable pin rise or power-on resets device
// - Enable pin ignores levels shorter than filter
// - Filtered enable level readable as status flag
// - Halt stops CPU clock until release
// - Halt honoured at any enable pin level
// - Peripherals keep running during halt
// - Halt carries four-bit release mask
// - Non-interrupt release resumes at next instruction
// - Enabled release conditions are ORed together
// - Any reset always ends halt state
// - All-zero mask: only reset ends halt
// - Key, timer carry, interrupt; bit two unused
// - Honoured stop halts the crystal oscillator
// - Key mask releases on any high key pin
// - Timer mask releases when carry flag set
// - Interrupt mask releases on acknowledge, branches vector
`include "shcs_consts.svh"

module shcs_top (
  input wire logic clk,                // System clock, 125 MHz
  input wire logic sys_rst,            // Power-on reset, synchronous, active high
  input wire logic clk_en,             // Freezes all state while low
  input wire logic [7:0] paddr,        // APB address
  input wire logic psel,               // APB select
  input wire logic penable,            // APB enable
  input wire logic pwrite,             // APB direction
  input wire logic [31:0] pwdata,      // APB write data
  input wire logic [3:0] pstrb,        // APB byte strobes
  output logic [31:0] prdata,          // APB read data
  output logic pready,                 // APB ready
  output logic pslverr,                // APB error
  input wire logic halt_exec,          // Halt instruction executes, pulse
  input wire logic [3:0] halt_mask,    // Halt operand, valid with halt_exec
  input wire logic stop_exec,          // Stop instruction executes, pulse
  input wire logic timer_carry,        // Timer carry flag level, same clock
  input wire logic irq_ack,            // Interrupt acknowledged, pulse
  input wire logic [3:0] key_pins,     // Key input port pins
  input wire logic dev_en_pin,         // Device enable pin
  output logic cpu_clk_en,             // CPU operation clock enable
  output logic periph_run,             // Peripheral hardware enable
  output logic osc_run,                // Crystal oscillator enable
  output logic dev_reset,              // Device reset to the core
  output logic resume_next,            // Pulse: continue after halt
  output logic vector_take,            // Pulse: branch to interrupt vector
  output logic dev_en_flag,            // Filtered enable level
  output logic halted                  // CPU held in halt
);

  // Pin synchronisers
  logic [3:0] key_meta;
  logic [3:0] key_sync;
  logic dev_en_meta;
  logic dev_en_sync;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      key_meta <= 4'h0;
      key_sync <= 4'h0;
      dev_en_meta <= 1'b0;
      dev_en_sync <= 1'b0;
    end else if (clk_en) begin
      key_meta <= key_pins;
      key_sync <= key_meta;
      dev_en_meta <= dev_en_pin;
      dev_en_sync <= dev_en_meta;
    end
  end

  // Enable pin noise filter
  logic [15:0] filt_len;
  wire logic dev_en_filt;
  wire logic dev_en_rise;

  shcs_filter u_filter (
    .clk(clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .level_in(dev_en_sync),
    .filt_len(filt_len),
    .level_out(dev_en_filt),
    .rise(dev_en_rise)
  );

  // Sticky flag update: a new event beats a clear in the same cycle
  function automatic logic [`SHCS_CA_WIDTH-1:0] sticky_next(
    input logic [`SHCS_CA_WIDTH-1:0] cur,
    input logic [`SHCS_CA_WIDTH-1:0] set,
    input logic [`SHCS_CA_WIDTH-1:0] clr
  );
    sticky_next = (cur & ~clr) | set;
  endfunction

  // Byte-lane merge for register writes
  function automatic logic [15:0] lane_merge(
    input logic [15:0] cur,
    input logic [15:0] wdat,
    input logic [1:0] strb
  );
    lane_merge = {strb[1] ? wdat[15:8] : cur[15:8], strb[0] ? wdat[7:0] : cur[7:0]};
  endfunction

  // Sequencer state
  shcs_pkg::shcs_state_t state;
  shcs_pkg::shcs_state_t next_state;
  shcs_pkg::shcs_mask_t held_mask;
  logic [7:0] rst_cnt;
  logic [`SHCS_CA_WIDTH-1:0] cause;

  // Release conditions
  wire logic key_any;
  wire logic rel_key;
  wire logic rel_tmr;
  wire logic rel_irq;
  wire logic rel_any;
  wire logic in_halt;
  wire logic in_run;
  wire logic in_reset;
  wire logic rst_done;
  wire logic stop_ok;
  wire logic stop_nop;
  wire logic halt_go;

  assign in_halt = state == shcs_pkg::SHCS_HALT;
  assign in_run = state == shcs_pkg::SHCS_RUN;
  assign in_reset = state == shcs_pkg::SHCS_RESET;
  assign key_any = |key_sync;
  // Mask bit two has no release source and is ignored
  assign rel_key = held_mask[`SHCS_HM_KEY] && key_any;
  assign rel_tmr = held_mask[`SHCS_HM_TIMER] && timer_carry;
  assign rel_irq = held_mask[`SHCS_HM_IRQ] && irq_ack;
  assign rel_any = in_halt && (rel_key || rel_tmr || rel_irq);
  assign rst_done = in_reset && (rst_cnt >= 8'(`SHCS_RST_CYCLES - 1));
  assign halt_go = in_run && halt_exec;
  assign stop_ok = in_run && !halt_exec && stop_exec && !dev_en_filt;
  assign stop_nop = in_run && !halt_exec && stop_exec && dev_en_filt;

  // Next state; an enable-pin rise overrides every other event
  always_comb begin
    next_state = state;
    case (state)
      shcs_pkg::SHCS_RESET: begin
        if (rst_done) begin
          next_state = shcs_pkg::SHCS_RUN;
        end
      end
      shcs_pkg::SHCS_RUN: begin
        if (halt_go) begin
          next_state = shcs_pkg::SHCS_HALT;
        end else if (stop_ok) begin
          next_state = shcs_pkg::SHCS_STOP;
        end
      end
      shcs_pkg::SHCS_HALT: begin
        if (rel_any) begin
          next_state = shcs_pkg::SHCS_RUN;
        end
      end
      shcs_pkg::SHCS_STOP: begin
        next_state = shcs_pkg::SHCS_STOP;
      end
      default: begin
        next_state = shcs_pkg::SHCS_RESET;
      end
    endcase
    if (dev_en_rise) begin
      next_state = shcs_pkg::SHCS_RESET;
    end
  end

  wire logic next_cpu_clk_en;
  wire logic next_periph_run;
  wire logic next_osc_run;
  wire logic next_dev_reset;
  wire logic next_resume;
  wire logic next_vector;

  assign next_cpu_clk_en = next_state == shcs_pkg::SHCS_RUN;
  // Halt does not touch peripherals; only the enable level, reset and stop do
  assign next_periph_run = dev_en_filt && (next_state == shcs_pkg::SHCS_RUN ||
                           next_state == shcs_pkg::SHCS_HALT);
  assign next_osc_run = next_state != shcs_pkg::SHCS_STOP;
  assign next_dev_reset = next_state == shcs_pkg::SHCS_RESET;
  assign next_resume = rel_any && !rel_irq && !dev_en_rise;
  assign next_vector = rel_any && rel_irq && !dev_en_rise;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= shcs_pkg::SHCS_RESET;
      rst_cnt <= 8'h00;
    end else if (clk_en) begin
      state <= next_state;
      if (next_state == shcs_pkg::SHCS_RESET && !in_reset) begin
        rst_cnt <= 8'h00;
      end else if (dev_en_rise) begin
        rst_cnt <= 8'h00;
      end else if (in_reset && !rst_done) begin
        rst_cnt <= 8'(rst_cnt + 8'h01);
      end
    end
  end

  // Release mask is captured with the halt instruction
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      held_mask <= 4'h0;
    end else if (clk_en && halt_go) begin
      held_mask <= halt_mask;
    end
  end

  // Output flops
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cpu_clk_en <= 1'b0;
      periph_run <= 1'b0;
      osc_run <= 1'b1;
      dev_reset <= 1'b1;
      resume_next <= 1'b0;
      vector_take <= 1'b0;
      dev_en_flag <= 1'b0;
      halted <= 1'b0;
    end else if (clk_en) begin
      cpu_clk_en <= next_cpu_clk_en;
      periph_run <= next_periph_run;
      osc_run <= next_osc_run;
      dev_reset <= next_dev_reset;
      resume_next <= next_resume;
      vector_take <= next_vector;
      dev_en_flag <= dev_en_filt;
      halted <= next_state == shcs_pkg::SHCS_HALT;
    end
  end

  // APB slave: ready one cycle into the access phase
  wire logic apb_access;
  wire logic apb_done;
  wire logic hit_status;
  wire logic hit_filter;
  wire logic hit_cause;
  wire logic hit_mask;
  wire logic hit_any;
  wire logic wr_ro;
  wire logic wr_filter;
  wire logic wr_cause;
  wire logic [31:0] status_word;
  wire logic [31:0] next_prdata;
  wire logic [`SHCS_CA_WIDTH-1:0] cause_set;
  wire logic [`SHCS_CA_WIDTH-1:0] cause_clr;

  assign apb_access = psel && penable && !pready;
  assign apb_done = psel && penable && pready;
  assign hit_status = paddr == `SHCS_OFS_STATUS;
  assign hit_filter = paddr == `SHCS_OFS_FILTER;
  assign hit_cause = paddr == `SHCS_OFS_CAUSE;
  assign hit_mask = paddr == `SHCS_OFS_MASK;
  assign hit_any = hit_status || hit_filter || hit_cause || hit_mask;
  assign wr_ro = pwrite && (hit_status || hit_mask);
  assign wr_filter = apb_done && pwrite && hit_filter;
  assign wr_cause = apb_done && pwrite && hit_cause && pstrb[0];

  assign status_word = {27'h000_0000, periph_run, in_reset,
                        state == shcs_pkg::SHCS_STOP, halted, dev_en_flag};

  assign next_prdata = hit_status ? status_word :
                       hit_filter ? {16'h0000, filt_len} :
                       hit_cause ? {26'h000_0000, cause} :
                       hit_mask ? {28'h000_0000, held_mask} : 32'h0000_0000;

  assign cause_set = {dev_en_rise, stop_nop, rel_irq && in_halt, 1'b0,
                      rel_tmr && in_halt, rel_key && in_halt};
  assign cause_clr = wr_cause ? pwdata[`SHCS_CA_WIDTH-1:0] : 6'h00;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (clk_en) begin
      pready <= apb_access;
      pslverr <= apb_access && (!hit_any || wr_ro);
      if (apb_access && !pwrite) begin
        prdata <= next_prdata;
      end
    end
  end

  // Filter length steers the enable pin filter
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      filt_len <= `SHCS_FILT_RESET;
    end else if (clk_en && wr_filter) begin
      filt_len <= lane_merge(filt_len, pwdata[15:0], pstrb[1:0]);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cause <= 6'h00;
    end else if (clk_en) begin
      cause <= sticky_next(cause, cause_set, cause_clr);
    end
  end

endmodule
